// [shared/pwit_pkg.sv]
// constants shared by the periodic wakeup interrupt timer
`default_nettype none
package pwit_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  // control/status field positions
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT  = 6;
  localparam int CLKS_BIT = 5;
  localparam int IE_BIT   = 4;
  localparam int PSEL_LSB = 0;
  localparam int PSEL_W   = 3;
  // status and mask hold one event bit
  localparam int EVT_BIT  = 0;
  // reset values
  localparam logic             CLKS_RST = 1'b0;
  localparam logic             IE_RST   = 1'b0;
  localparam logic [PSEL_W-1:0] PSEL_RST = 3'h0;
  localparam logic             FLAG_RST = 1'b0;
  localparam logic             MASK_RST = 1'b1;
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int         HTRANS_ACT = 1;
  // timing: bus clock period and reference period in their own units
  localparam int CLK_PERIOD_NS = 40;
  localparam int REF_PERIOD_US = 1000;
  localparam int REF_DIV_CYCLES = (REF_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int PRESC_W = 15;
  // period lengths in source ticks; index 0 means stopped
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] PERIOD_TICKS [0:7] = '{
    11'h000, 11'h008, 11'h020, 11'h040,
    11'h080, 11'h100, 11'h200, 11'h400
  };
endpackage
`default_nettype wire

// [logic/pwit_sync.sv]
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module pwit_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output var  logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;

  // level changes only once stages two and three agree
  always_comb
  begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
    rise_d  = level_d & ~level_q;
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end

  assign rise = rise_q;
endmodule
`default_nettype wire

// [logic/pwit_timer.sv]
// periodic wakeup interrupt timer with ahb-lite register slave
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwit_timer
#(
  parameter int REF_DIV = pwit_pkg::REF_DIV_CYCLES
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        ext_clk_pin,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic        irq
);
  localparam int PW = pwit_pkg::PSEL_W;
  localparam int CW = pwit_pkg::CNT_W;
  localparam int SW = pwit_pkg::PRESC_W;

  // bus state
  logic [7:0]  addr_q;
  logic [7:0]  addr_d;
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic        rd_pend_q;
  logic        rd_pend_d;
  logic        hready_q;
  logic        hready_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        hresp_q;
  // register state
  logic          clks_q;
  logic          clks_d;
  logic          ie_q;
  logic          ie_d;
  logic [PW-1:0] psel_q;
  logic [PW-1:0] psel_d;
  logic          flag_q;
  logic          flag_d;
  logic          mask_q;
  logic          mask_d;
  logic          irq_q;
  logic          irq_d;
  // timer state
  logic [pwit_pkg::PRESC_W-1:0] presc_q;
  logic [pwit_pkg::PRESC_W-1:0] presc_d;
  logic [CW-1:0]                count_q;
  logic [CW-1:0]                count_d;
  // decode and timer terms
  logic          accept;
  logic          ctrl_wr;
  logic          stat_wr;
  logic          mask_wr;
  logic          ack;
  logic          ref_tick;
  logic          ext_rise;
  logic          tick;
  logic [CW-1:0] limit;
  logic          timeout;

  // external clock crosses in through the agreement synchroniser
  pwit_sync u_ext_sync
  (
    .clk      (hclk),
    .rst_n    (hresetn),
    .async_in (ext_clk_pin),
    .rise     (ext_rise)
  );

  // address phase taken only for active word transfers
  always_comb
  begin
    accept    = hsel & hready & htrans[pwit_pkg::HTRANS_ACT] &
                (hsize == pwit_pkg::HSIZE_WORD);
    addr_d    = accept ? haddr[7:0] : addr_q;
    wr_pend_d = accept & hwrite;
    rd_pend_d = accept & ~hwrite;
    // one wait state on reads so a preceding write is always seen
    hready_d  = ~(accept & ~hwrite);
    rdata_d   = rdata_q;
    if (rd_pend_q)
    begin
      case (addr_q)
        pwit_pkg::OFF_CTRL:
        begin
          rdata_d = 32'h0000_0000;
          rdata_d[pwit_pkg::FLAG_BIT] = flag_q;
          rdata_d[pwit_pkg::CLKS_BIT] = clks_q;
          rdata_d[pwit_pkg::IE_BIT]   = ie_q;
          rdata_d[pwit_pkg::PSEL_LSB +: PW] = psel_q;
        end
        pwit_pkg::OFF_STAT:
        begin
          rdata_d = 32'h0000_0000;
          rdata_d[pwit_pkg::EVT_BIT] = flag_q;
        end
        pwit_pkg::OFF_MASK:
        begin
          rdata_d = 32'h0000_0000;
          rdata_d[pwit_pkg::EVT_BIT] = mask_q;
        end
        default:
        begin
          rdata_d = 32'h0000_0000; // unmapped reads give zero
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hready_q  <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      hresp_q   <= 1'b0;
    end
    else
    begin
      addr_q    <= addr_d;
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      hready_q  <= hready_d;
      rdata_q   <= rdata_d;
      hresp_q   <= 1'b0; // always okay
    end
  end

  // write data phase decode and register updates
  always_comb
  begin
    ctrl_wr = wr_pend_q & (addr_q == pwit_pkg::OFF_CTRL);
    stat_wr = wr_pend_q & (addr_q == pwit_pkg::OFF_STAT);
    mask_wr = wr_pend_q & (addr_q == pwit_pkg::OFF_MASK);
    ack     = (ctrl_wr & hwdata[pwit_pkg::ACK_BIT]) |
              (stat_wr & hwdata[pwit_pkg::EVT_BIT]);
    clks_d  = ctrl_wr ? hwdata[pwit_pkg::CLKS_BIT] : clks_q;
    ie_d    = ctrl_wr ? hwdata[pwit_pkg::IE_BIT] : ie_q;
    psel_d  = ctrl_wr ? hwdata[pwit_pkg::PSEL_LSB +: PW] : psel_q;
    mask_d  = mask_wr ? hwdata[pwit_pkg::EVT_BIT] : mask_q;
    // a time-out in the clearing cycle wins over the clear
    if (timeout)
      flag_d = 1'b1;
    else if (ack)
      flag_d = 1'b0;
    else
      flag_d = flag_q;
    irq_d   = flag_d & ie_d & mask_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clks_q <= pwit_pkg::CLKS_RST;
      ie_q   <= pwit_pkg::IE_RST;
      psel_q <= pwit_pkg::PSEL_RST;
      flag_q <= pwit_pkg::FLAG_RST;
      mask_q <= pwit_pkg::MASK_RST;
      irq_q  <= 1'b0;
    end
    else
    begin
      clks_q <= clks_d;
      ie_q   <= ie_d;
      psel_q <= psel_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  // prescaler and period counter; no power-mode gating at all
  always_comb
  begin
    ref_tick = (presc_q == SW'(REF_DIV - 1));
    presc_d  = ref_tick ? '0 : presc_q + SW'(1);
    tick     = clks_q ? ext_rise : ref_tick;
    limit    = pwit_pkg::PERIOD_TICKS[psel_q];
    // compare with >= so a shorter new period never runs a full wrap
    timeout  = (psel_q != PW'(0)) & tick &
               (count_q >= limit - CW'(1));
    if (psel_q == PW'(0))
      count_d = '0;
    else if (timeout)
      count_d = '0;
    else if (tick)
      count_d = count_q + CW'(1);
    else
      count_d = count_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presc_q <= '0;
      count_q <= '0;
    end
    else
    begin
      presc_q <= presc_d;
      count_q <= count_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = hready_q;
  assign hresp     = hresp_q;
  assign irq       = irq_q;

  // checks on the block's own behaviour
  sequence s_read_taken;
    hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    s_read_taken |=> s_read_answer;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer not after one wait state");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    timeout |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("time-out did not set the flag");

  property p_restart;
    @(posedge hclk) disable iff (!hresetn)
    timeout |=> count_q == 11'h000 && !timeout;
  endproperty
  a_restart: assert property (p_restart)
    else $error("next period did not restart from zero");

  property p_ack_clear;
    @(posedge hclk) disable iff (!hresetn)
    ctrl_wr && hwdata[6] && !timeout |=> !flag_q && !irq_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear flag and request");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
    irq_q == (flag_q && ie_q && mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with flag and enables");

  property p_stopped;
    @(posedge hclk) disable iff (!hresetn)
    psel_q == 3'h0 |-> !timeout ##1 count_q == 11'h000;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("time-out while period select is zero");

  property p_ext_source;
    @(posedge hclk) disable iff (!hresetn)
    clks_q |-> tick == ext_rise;
  endproperty
  a_ext_source: assert property (p_ext_source)
    else $error("external source not steering the tick");

  property p_int_source;
    @(posedge hclk) disable iff (!hresetn)
    !clks_q && presc_q == 15'(REF_DIV - 1) |-> tick ##1 presc_q == 15'h0000;
  endproperty
  a_int_source: assert property (p_int_source)
    else $error("internal reference tick missing");

  property p_count_bound;
    @(posedge hclk) disable iff (!hresetn)
    // no control write here, so the limit still stands one cycle later
    psel_q != 3'h0 && !ctrl_wr && count_q < limit
      |=> count_q < pwit_pkg::PERIOD_TICKS[psel_q];
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("period counter ran past its limit");

  property p_write_57;
    @(posedge hclk) disable iff (!hresetn)
    ctrl_wr && hwdata[7:0] == 8'h57 && !timeout
      |=> !clks_q && ie_q && psel_q == 3'h7 && !flag_q &&
          limit == 11'h400;
  endproperty
  a_write_57: assert property (p_write_57)
    else $error("0x57 did not give the one-second setup");
endmodule
`default_nettype wire

// [testbench/periodic_wakeup_interrupt_timer_tb_top.sv]
// self-checking bench for the periodic wakeup interrupt timer
`timescale 1ns/1ps
`default_nettype none
module periodic_wakeup_interrupt_timer_tb_top;
  // short reference divider keeps the longest period at 4096 cycles
  localparam int DIV = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        ext_pin = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t0;
  int          t1;

  // clock and free cycle count for period measurement
  always #20 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  pwit_timer #(.REF_DIV(DIV)) pwit_timer_inst
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (1'b1),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (pwit_pkg::HSIZE_WORD),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .ext_clk_pin (ext_pin),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .irq         (irq)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single ahb-lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string nm);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(nm, exp, d);
  endtask

  // bounded wait for the request; time stamp of first high sample
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 9000)
    begin
      @(posedge hclk);
      k++;
    end
    t = cyc;
    check("irq wait", 32'h1, irq);
  endtask

  // acknowledge keeps enable and select; request must be gone after
  task automatic ack(input logic [2:0] s);
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0050 | s);
    repeat (2) @(posedge hclk);
    check("irq after ack", 32'h0, irq);
  endtask

  // pin pulse wider than the synchroniser filter needs
  task automatic pulse();
    ext_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    ext_pin <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask

  // hang guard, well beyond the expected run of about 17000 cycles
  initial
  begin
    repeat (60000) @(posedge hclk);
    fails++;
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("hresp", 32'h0, hresp);
    check("irq reset", 32'h0, irq);
    rdc(pwit_pkg::OFF_CTRL, 32'h0000_0000, "ctrl reset");
    rdc(pwit_pkg::OFF_STAT, 32'h0000_0000, "stat reset");
    rdc(pwit_pkg::OFF_MASK, 32'h0000_0001, "mask reset");
    // unmapped place: write dropped, read zero
    wr(8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0000_0000, "unmapped");
    // enable off: flag still sets, no request
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (40) @(posedge hclk);
    check("irq ie off", 32'h0, irq);
    rdc(pwit_pkg::OFF_STAT, 32'h0000_0001, "stat flag");
    rdc(pwit_pkg::OFF_CTRL, 32'h0000_0081, "ctrl flag");
    wr(pwit_pkg::OFF_STAT, 32'h0000_0001);
    rdc(pwit_pkg::OFF_STAT, 32'h0000_0000, "stat clear");
    // masked out: flag sets, request held low
    wr(pwit_pkg::OFF_MASK, 32'h0000_0000);
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0051);
    repeat (40) @(posedge hclk);
    check("irq masked", 32'h0, irq);
    rdc(pwit_pkg::OFF_STAT, 32'h0000_0001, "stat masked");
    wr(pwit_pkg::OFF_MASK, 32'h0000_0001);
    // select zero keeps the counter at zero: no time-out at all
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0050);
    repeat (200) @(posedge hclk);
    check("irq stopped", 32'h0, irq);
    rdc(pwit_pkg::OFF_STAT, 32'h0000_0000, "stat stopped");
    // every period: rise to rise distance with an ack in between
    for (int s = 1; s < 8; s++)
    begin
      wr(pwit_pkg::OFF_CTRL, 32'h0000_0050 | s);
      rdc(pwit_pkg::OFF_CTRL, 32'h0000_0010 | s, "ctrl sel");
      wait_irq(t0);
      ack(s);
      wait_irq(t1);
      check("period", pwit_pkg::PERIOD_TICKS[s] * DIV, t1 - t0);
      ack(s);
    end
    // external source: the internal tick must not count now
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0050);
    wr(pwit_pkg::OFF_CTRL, 32'h0000_0031);
    repeat (7) pulse();
    repeat (10) @(posedge hclk);
    check("irq ext 7", 32'h0, irq);
    pulse();
    repeat (10) @(posedge hclk);
    check("irq ext 8", 32'h1, irq);
    rdc(pwit_pkg::OFF_CTRL, 32'h0000_00B1, "ctrl ext");
    final_report();
  end
endmodule
`default_nettype wire
